/* File: shared/rsf_cfg.svh */
// timing, offsets and field positions for the serial frame and command block
// assumes a 100 MHz system clock
`ifndef RSF_CFG_SVH
`define RSF_CFG_SVH

`define RSF_CLK_MHZ        100
`define RSF_CHAR_TIME_US   573
`define RSF_SILENCE_TIME_NS 2005000
`define RSF_SILENCE_CYC    ((`RSF_SILENCE_TIME_NS * `RSF_CLK_MHZ) / 1000)
`define RSF_CHAR_CYC       (`RSF_CHAR_TIME_US * `RSF_CLK_MHZ)
`define RSF_MAX_BYTES      64
`define RSF_BCAST_ADDR     8'h00
`define RSF_FC_WRITE_ONE   8'h06
`define RSF_REG_CMD_WORD   16'h02AA
`define RSF_REG_SPEED      16'h02AB
`define RSF_CMD_RESET      16'h0000
`define RSF_SPEED_RESET    16'h0000
`define RSF_CRC_INIT       16'hFFFF
`define RSF_CRC_POLY       16'hA001
`define RSF_BIT_RUN        0
`define RSF_BIT_ENABLE     1
`define RSF_BIT_DIR        2
`define RSF_BIT_JOG        3
`define RSF_BIT_REMOTE     4
`define RSF_BIT_RAMP2      5
`define RSF_BIT_FAULT_RST  7
`define RSF_CMD_USED_MASK  16'h00BF

`endif

/* File: shared/rsf_pkg.sv */
// types for the serial frame and command block
// assumes rsf_cfg.svh for numeric constants
package rsf_pkg;
	typedef struct packed {
		logic run;
		logic enable;
		logic forward;
		logic jog;
		logic remote;
		logic ramp2;
		logic fault_reset;
	} rsf_cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic       valid;
	} rsf_byte_t;

	typedef enum logic [1:0] {
		RSF_IDLE,
		RSF_RECV,
		RSF_DROP,
		RSF_SEND
	} rsf_state_t;
endpackage

/* File: logic/rsf_frame_cmd.sv */
// rtu slave frame delimiting, address/crc check and serial command registers
// assumes a uart outside delivers received bytes and sends reply bytes,
// with byte format set by that uart; only function 06 writes are handled here
//
// Functional notes
// RL1 - command word and speed setpoint are written only from the serial link
// RL2 - command bits act only when serial control source is selected; bit 2 still steers dir_forward_out whenever serial_ref_sel_in is set
// RL3 - bit 0 runs up accel ramp when set, decel stop when clear
// RL4 - bit 1 enables drive when set, removes motor supply when clear
// RL5 - bit 2 keeps reference direction when set, reverses when clear
// RL6 - bit 3 enables jog when set
// RL7 - bit 4 selects remote when set, local when clear
// RL8 - bit 5 selects second ramp pair when set
// RL9 - bit 7 resets a fault; bits 6 and 8-15 reserved
// RL10 - speed setpoint signed 16 bits, resets to zero, used only if serial source
// RL11 - setpoint 8192 means rated frequency, zero means zero speed
// RL12 - final direction is setpoint sign, inverted when bit 2 clear
// RL13 - binary rtu framing only; byte format follows a setting
// RL14 - telegram is address, function, data, two check bytes
// RL15 - one master starts every exchange; only addressed slave replies
// RL16 - reply starts with own configured slave address
// RL17 - address zero is processed but never answered
// RL18 - crc-16 sent low byte first then high byte
// RL19 - silence of 3.5 character times delimits telegrams
// RL20 - overlong gap inside a telegram discards bytes so far
// RL21 - above 19200 bit/s use 573 us character and 2.005 ms silence
// RL22 - telegrams at most 64 bytes
// RL23 - bad crc or foreign address drops the telegram silently
`timescale 1ns/100ps
`include "rsf_cfg.svh"

module rsf_frame_cmd (
	// clock and reset
	input  wire logic              clk_in,
	input  wire logic              nrst_in,
	// received bytes from the uart
	input  wire logic              rx_valid_in,
	input  wire logic [7:0]        rx_data_in,
	// reply bytes to the uart
	output logic                   tx_valid_out,
	output logic [7:0]             tx_data_out,
	input  wire logic              tx_ready_in,
	// configuration from the drive
	input  wire logic [7:0]        slave_addr_in,
	input  wire logic [15:0]       silence_cyc_in,
	input  wire logic              serial_ctrl_sel_in,
	input  wire logic              serial_ref_sel_in,
	// commands to the drive
	output rsf_pkg::rsf_cmd_t      cmd_out,
	output logic signed [15:0]     speed_ref_out,
	output logic                   dir_forward_out,
	// register readback for other sources
	output logic [15:0]            serial_command_word_out,
	output logic [15:0]            serial_speed_setpoint_out,
	// frame status
	output logic                   frame_drop_out
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `RSF_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] own);
		return (a == own) || (a == `RSF_BCAST_ADDR);
	endfunction

	// ------------------------------------------------------------
	// input synchronisers and state
	// ------------------------------------------------------------
	logic                rx_v_s1;
	logic                rx_v_s2;
	logic                rx_v_d;
	logic [7:0]          rx_d_s1;
	logic [7:0]          rx_d_s2;
	logic                rx_stb;
	rsf_pkg::rsf_state_t state;
	logic [7:0]          buf_mem [0:`RSF_MAX_BYTES-1];
	logic [6:0]          count;
	logic [15:0]         crc;
	logic [22:0]         gap;
	logic [22:0]         gap_lim;
	logic                gap_done;
	logic [15:0]         cmd_word;
	logic [15:0]         speed_sp;
	logic [7:0]          tx_buf [0:7];
	logic [3:0]          tx_idx;
	logic [3:0]          tx_len;
	logic                frame_ok;
	logic [15:0]         w_reg;
	logic [15:0]         w_val;

	// rx is asynchronous to this clock; strobe is the rising edge of the second stage against its delayed copy
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_v_s1 <= 1'b0;
			rx_v_s2 <= 1'b0;
			rx_v_d  <= 1'b0;
			rx_d_s1 <= 8'h00;
			rx_d_s2 <= 8'h00;
		end else begin
			rx_v_s1 <= rx_valid_in;
			rx_v_s2 <= rx_v_s1;
			rx_v_d  <= rx_v_s2;
			rx_d_s1 <= rx_data_in;
			rx_d_s2 <= rx_d_s1;
		end
	end
	assign rx_stb = rx_v_s2 & ~rx_v_d;                 // see RL13

	// ------------------------------------------------------------
	// silence timer
	// ------------------------------------------------------------
	// floor at the 19200 bit/s silence so faster links keep that gap
	assign gap_lim  = ({7'h00, silence_cyc_in} < 23'(`RSF_SILENCE_CYC)) ?
		23'(`RSF_SILENCE_CYC) : {7'h00, silence_cyc_in};   // see RL21
	assign gap_done = (gap >= gap_lim);                   // see RL19

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			gap <= 23'h000000;
		end else if (rx_stb) begin
			gap <= 23'h000000;
		end else if (!gap_done) begin
			gap <= gap + 23'h000001;
		end
	end

	// ------------------------------------------------------------
	// telegram decode
	// ------------------------------------------------------------
	assign w_reg    = {buf_mem[2], buf_mem[3]};
	assign w_val    = {buf_mem[4], buf_mem[5]};
	// crc over the whole telegram including check bytes nets to zero
	assign frame_ok = (count >= 7'h04) && (crc == 16'h0000)
		&& addr_hit(buf_mem[0], slave_addr_in);           // see RL14 see RL18 see RL23

	// ------------------------------------------------------------
	// receive / reply state machine
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state          <= rsf_pkg::RSF_IDLE;
			count          <= 7'h00;
			crc            <= `RSF_CRC_INIT;
			tx_idx         <= 4'h0;
			tx_len         <= 4'h0;
			frame_drop_out <= 1'b0;
		end else begin
			frame_drop_out <= 1'b0;
			case (state)
				rsf_pkg::RSF_IDLE: begin
					// a byte here starts a new telegram; the silence timer is not checked in this state
					if (rx_stb) begin
						count <= 7'h01;
						crc   <= crc_step(`RSF_CRC_INIT, rx_d_s2);   // see RL19
						state <= rsf_pkg::RSF_RECV;
					end
				end
				rsf_pkg::RSF_RECV: begin
					// byte after an overlong gap restarts the telegram
					if (rx_stb && gap_done) begin
						count <= 7'h01;                                 // see RL20
						crc   <= crc_step(`RSF_CRC_INIT, rx_d_s2);
					end else if (rx_stb) begin
						if (count == 7'(`RSF_MAX_BYTES)) begin
							state <= rsf_pkg::RSF_DROP;             // see RL22
						end else begin
							count <= count + 7'h01;
							crc   <= crc_step(crc, rx_d_s2);
						end
					end else if (gap_done) begin
						// end of telegram after silence
						if (!frame_ok) begin
							frame_drop_out <= 1'b1;                 // see RL23
							state          <= rsf_pkg::RSF_IDLE;
						end else if (buf_mem[0] == `RSF_BCAST_ADDR
							|| buf_mem[1] != `RSF_FC_WRITE_ONE || count != 7'h08) begin
							state <= rsf_pkg::RSF_IDLE;             // see RL17
						end else begin
							tx_idx <= 4'h0;
							tx_len <= 4'h8;
							state  <= rsf_pkg::RSF_SEND;            // see RL15
						end
					end
				end
				rsf_pkg::RSF_DROP: begin
					// overlong telegram is thrown away until silence
					if (gap_done && !rx_stb) begin
						frame_drop_out <= 1'b1;
						state          <= rsf_pkg::RSF_IDLE;
					end
				end
				rsf_pkg::RSF_SEND: begin
					if (tx_ready_in) begin
						if (tx_idx == tx_len - 4'h1) begin
							state <= rsf_pkg::RSF_IDLE;
						end
						tx_idx <= tx_idx + 4'h1;
					end
				end
				default: state <= rsf_pkg::RSF_IDLE;
			endcase
		end
	end
	// receive buffer
	always_ff @(posedge clk_in) begin
		if (rx_stb && (state == rsf_pkg::RSF_IDLE || gap_done)) begin
			buf_mem[0] <= rx_d_s2;
		end else if (rx_stb && (state == rsf_pkg::RSF_RECV)
			&& (count < 7'(`RSF_MAX_BYTES))) begin
			buf_mem[count[5:0]] <= rx_d_s2;
		end
	end

	// ------------------------------------------------------------
	// reply: echo of the write with own address and fresh crc
	// ------------------------------------------------------------
	logic [15:0] reply_crc;
	always_comb begin
		reply_crc = `RSF_CRC_INIT;
		reply_crc = crc_step(reply_crc, slave_addr_in);
		for (int i = 1; i < 6; i++) begin
			reply_crc = crc_step(reply_crc, buf_mem[i]);
		end
	end

	always_ff @(posedge clk_in) begin
		if (state == rsf_pkg::RSF_RECV && gap_done) begin
			tx_buf[0] <= slave_addr_in;                      // see RL16
			tx_buf[1] <= buf_mem[1];
			tx_buf[2] <= buf_mem[2];
			tx_buf[3] <= buf_mem[3];
			tx_buf[4] <= buf_mem[4];
			tx_buf[5] <= buf_mem[5];
			tx_buf[6] <= reply_crc[7:0];                     // see RL18
			tx_buf[7] <= reply_crc[15:8];
		end
	end

	assign tx_valid_out = (state == rsf_pkg::RSF_SEND);
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_data_out <= 8'h00;
		end else begin
			tx_data_out <= tx_buf[tx_idx[2:0]];
		end
	end

	// ------------------------------------------------------------
	// command registers: written only by a valid serial write
	// ------------------------------------------------------------
	logic do_write;
	assign do_write = (state == rsf_pkg::RSF_RECV) && !rx_stb && gap_done && frame_ok
		&& buf_mem[1] == `RSF_FC_WRITE_ONE && count == 7'h08;   // see RL1 see RL17

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cmd_word <= `RSF_CMD_RESET;
		end else if (do_write && w_reg == `RSF_REG_CMD_WORD) begin
			cmd_word <= w_val & `RSF_CMD_USED_MASK;          // see RL9
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			speed_sp <= `RSF_SPEED_RESET;                    // see RL10
		end else if (do_write && w_reg == `RSF_REG_SPEED) begin
			speed_sp <= w_val;
		end
	end

	assign serial_command_word_out   = cmd_word;
	assign serial_speed_setpoint_out = speed_sp;

	// ------------------------------------------------------------
	// command outputs, forced to zero unless serial source selected
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cmd_out <= '0;
		end else if (serial_ctrl_sel_in) begin                    // see RL2
			cmd_out.run         <= cmd_word[`RSF_BIT_RUN];        // see RL3
			cmd_out.enable      <= cmd_word[`RSF_BIT_ENABLE];     // see RL4
			cmd_out.forward     <= cmd_word[`RSF_BIT_DIR];        // see RL5
			cmd_out.jog         <= cmd_word[`RSF_BIT_JOG];        // see RL6
			cmd_out.remote      <= cmd_word[`RSF_BIT_REMOTE];     // see RL7
			cmd_out.ramp2       <= cmd_word[`RSF_BIT_RAMP2];      // see RL8
			cmd_out.fault_reset <= cmd_word[`RSF_BIT_FAULT_RST];  // see RL9
		end else begin
			cmd_out <= '0;
		end
	end

	// scale passes through: 8192 is rated frequency
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			speed_ref_out   <= 16'sh0000;
			dir_forward_out <= 1'b0;
		end else if (serial_ref_sel_in) begin                     // see RL10
			speed_ref_out   <= speed_sp;                          // see RL11
			dir_forward_out <= (speed_sp[15] == 1'b0) ~^ cmd_word[`RSF_BIT_DIR];  // see RL12
		end else begin
			speed_ref_out   <= 16'sh0000;
			dir_forward_out <= 1'b0;
		end
	end

endmodule

/* File: tb/rsf_frame_cmd_props.sv */
// concurrent checks on the ports of the serial frame and command block
// assumes one clock domain and the constants of rsf_cfg.svh
`timescale 1ns/100ps
`include "rsf_cfg.svh"
module rsf_frame_cmd_props (
	// clock and reset
	input wire logic              clk_in,
	input wire logic              nrst_in,
	// byte streams
	input wire logic              rx_valid_in,
	input wire logic              tx_valid_out,
	input wire logic              tx_ready_in,
	// selects
	input wire logic              serial_ctrl_sel_in,
	input wire logic              serial_ref_sel_in,
	// outputs watched
	input wire rsf_pkg::rsf_cmd_t cmd_out,
	input wire logic signed [15:0] speed_ref_out,
	input wire logic              dir_forward_out,
	input wire logic [15:0]       serial_command_word_out,
	input wire logic [15:0]       serial_speed_setpoint_out,
	input wire logic              frame_drop_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	logic [15:0] w;
	logic [15:0] sp;
	assign w = serial_command_word_out;
	assign sp = serial_speed_setpoint_out;

	a_cmd_gated: assert property (!serial_ctrl_sel_in [*3] |-> cmd_out == '0)
		else $error("command outputs live without serial control");
	a_spd_gated: assert property (!serial_ref_sel_in [*3] |-> speed_ref_out == '0)
		else $error("speed output live without serial source");
	a_cmd_bits_follow: assert property ((serial_ctrl_sel_in && $stable(w)) [*3] |->
		cmd_out == {w[0], w[1], w[2], w[3], w[4], w[5], w[7]})
		else $error("command bits do not follow the command word");
	a_spd_follow: assert property ((serial_ref_sel_in && $stable(sp)) [*3] |->
		speed_ref_out == sp)
		else $error("speed output does not follow the setpoint");
	a_dir_sign: assert property ((serial_ref_sel_in && $stable(w) && $stable(sp)) [*3] |->
		dir_forward_out == (sp[15] ^ w[2]))
		else $error("final direction wrong");
	a_reserved_zero: assert property ((w & ~`RSF_CMD_USED_MASK) == 16'h0000)
		else $error("reserved command bits read nonzero");
	a_reply_stands: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out)
		else $error("reply dropped before completion");
	a_drop_pulse: assert property (frame_drop_out |=> !frame_drop_out)
		else $error("drop flag longer than one cycle");
	a_drop_silent: assert property (frame_drop_out |-> !tx_valid_out)
		else $error("reply sent for a dropped telegram");
	a_no_early_reply: assert property ($rose(rx_valid_in) && !tx_valid_out |=> !tx_valid_out [*8])
		else $error("reply started inside a telegram");

	c_reply: cover property ($rose(tx_valid_out));
	c_drop: cover property (frame_drop_out);
	c_cmd_live: cover property (cmd_out != '0);
endmodule

bind rsf_frame_cmd rsf_frame_cmd_props u_props (.clk_in(clk_in), .nrst_in(nrst_in),
	.rx_valid_in(rx_valid_in), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
	.serial_ctrl_sel_in(serial_ctrl_sel_in), .serial_ref_sel_in(serial_ref_sel_in),
	.cmd_out(cmd_out), .speed_ref_out(speed_ref_out), .dir_forward_out(dir_forward_out),
	.serial_command_word_out(serial_command_word_out),
	.serial_speed_setpoint_out(serial_speed_setpoint_out), .frame_drop_out(frame_drop_out));

/* File: tb/rsf_master_model.sv */
// bus master model: sends requests as byte strobes, collects reply bytes
// assumes the uart handshake of the block; a reply byte is read after its accept
`timescale 1ns/100ps
`include "rsf_cfg.svh"
module rsf_master_model (
	// clock
	input  wire logic       clk_in,
	// request bytes
	output logic            rx_valid_out,
	output logic [7:0]      rx_data_out,
	// reply bytes
	input  wire logic       tx_valid_in,
	input  wire logic [7:0] tx_data_in,
	output logic            tx_ready_out,
	// pacing
	input  wire logic       slow_in
);
	logic [7:0] got[$];
	logic       take = 1'b0;
	initial begin
		rx_valid_out = 1'b0;
		rx_data_out = 8'h00;
		tx_ready_out = 1'b0;
	end

	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = `RSF_CRC_INIT;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ `RSF_CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	// bytes sent close together; check field low byte first
	task automatic send(input logic [7:0] b[$], input logic bad, output logic [7:0] s[$]);
		logic [15:0] c;
		c = crc16(b) ^ {15'h0000, bad};
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		foreach (b[i]) begin
			@(posedge clk_in) #1;
			rx_data_out = b[i];
			rx_valid_out = 1'b1;
			repeat (4) @(posedge clk_in);
			#1;
			rx_valid_out = 1'b0;
			// released data line must not keep the last value
			rx_data_out = ~b[i];
			repeat (3) @(posedge clk_in);
		end
		s = b;
	endtask

	always @(posedge clk_in) begin
		if (take)
			got.push_back(tx_data_in);
		take <= tx_valid_in && tx_ready_out;
		tx_ready_out <= #1 slow_in ? ~tx_ready_out : 1'b1;
	end
endmodule

/* File: tb/tb.sv */
// testbench: write telegrams through the master model and compare results
// assumes the silence floor of 200500 cycles closes every telegram
`timescale 1ns/100ps
`include "rsf_cfg.svh"
module tb;
	logic              clk_in = 1'b0;
	logic              nrst_in = 1'b0;
	logic              rx_valid, tx_valid, tx_ready, frame_drop, dir_fwd;
	logic              slow = 1'b0, ctrl_sel = 1'b1, ref_sel = 1'b1, drop_seen = 1'b0;
	logic [7:0]        rx_data, tx_data;
	rsf_pkg::rsf_cmd_t cmd;
	logic signed [15:0] speed_ref;
	logic [15:0]       word_rb, spd_rb;
	int                failures = 0, n_checks = 0, cycles = 0;

	always #5 clk_in = ~clk_in;

	rsf_frame_cmd uut (.clk_in(clk_in), .nrst_in(nrst_in), .rx_valid_in(rx_valid),
		.rx_data_in(rx_data), .tx_valid_out(tx_valid), .tx_data_out(tx_data),
		.tx_ready_in(tx_ready), .slave_addr_in(8'h03), .silence_cyc_in(16'h0100),
		.serial_ctrl_sel_in(ctrl_sel), .serial_ref_sel_in(ref_sel), .cmd_out(cmd),
		.speed_ref_out(speed_ref), .dir_forward_out(dir_fwd),
		.serial_command_word_out(word_rb), .serial_speed_setpoint_out(spd_rb),
		.frame_drop_out(frame_drop));
	rsf_master_model pm (.clk_in(clk_in), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
		.tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_ready_out(tx_ready), .slow_in(slow));

	task automatic results();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	// one write telegram; reply must echo the request, else nothing at all
	task automatic frame(input logic [7:0] a, input logic [15:0] ra, input logic [15:0] v,
		input logic bad, input logic reply);
		logic [7:0] s[$];
		pm.got.delete();
		drop_seen = 1'b0;
		pm.send('{a, `RSF_FC_WRITE_ONE, ra[15:8], ra[7:0], v[15:8], v[7:0]}, bad, s);
		repeat (200500 + 300) @(posedge clk_in);
		check(16'(pm.got.size()), reply ? 16'h0008 : 16'h0000);
		check({15'h0000, drop_seen}, {15'h0000, bad || (a != 8'h03 && a != 8'h00)});
		if (reply && pm.got.size() == 8)
			foreach (s[i])
				check({8'h00, pm.got[i]}, {8'h00, s[i]});
	endtask

	always @(posedge clk_in) begin
		if (frame_drop === 1'b1)
			drop_seen <= 1'b1;
		cycles++;
		if (cycles == 1500000) begin
			failures++;
			results();
		end
	end

	initial begin
		repeat (10) @(posedge clk_in);
		#1 nrst_in = 1'b1;
		check(word_rb, `RSF_CMD_RESET);
		check(spd_rb, `RSF_SPEED_RESET);
		slow = 1'b1;
		frame(8'h03, `RSF_REG_CMD_WORD, 16'h0055, 1'b0, 1'b1);
		check(word_rb, 16'h0015);
		check({9'h000, cmd}, 16'h0054);
		slow = 1'b0;
		frame(8'h03, `RSF_REG_CMD_WORD, 16'hFFAA, 1'b0, 1'b1);
		check(word_rb, 16'h00AA);
		check({9'h000, cmd}, 16'h002B);
		@(posedge clk_in) #1 ctrl_sel = 1'b0;
		repeat (4) @(posedge clk_in);
		check({9'h000, cmd}, 16'h0000);
		check(word_rb, 16'h00AA);
		frame(`RSF_BCAST_ADDR, `RSF_REG_SPEED, 16'hE000, 1'b0, 1'b0);
		check(spd_rb, 16'hE000);
		check(speed_ref, 16'hE000);
		check({15'h0000, dir_fwd}, 16'h0001);
		@(posedge clk_in) #1 ref_sel = 1'b0;
		repeat (4) @(posedge clk_in);
		check(speed_ref, 16'h0000);
		frame(8'h03, `RSF_REG_SPEED, 16'h1000, 1'b1, 1'b0);
		check(spd_rb, 16'hE000);
		frame(8'h05, `RSF_REG_SPEED, 16'h2000, 1'b0, 1'b0);
		check(spd_rb, 16'hE000);
		results();
	end
endmodule
